// [pkg/sram_host_pkg.sv]
// Constants, states and carrier types for the static RAM host controller.
// Assumes a single 20 MHz clock domain and an asynchronous 32K x 8 memory.
package sram_host_pkg;

   // ----------------------------------------------------------------
   // Geometry and clock
   // ----------------------------------------------------------------
   localparam int ADDR_W       = 15;
   localparam int DATA_W       = 8;
   localparam int CLK_PERIOD_NS = 50;

   // ----------------------------------------------------------------
   // Timing, figures in their own units and derived cycle counts
   // ----------------------------------------------------------------
   localparam int ADDR_VALID_NS   = 70;   // Slower grade covers both grades
   localparam int DATA_SETUP_NS   = 35;
   localparam int WE_HIZ_NS       = 30;
   localparam int OUT_ACTIVE_NS   = 10;
   localparam int READ_ACCESS_NS  = 85;
   localparam int DESEL_RET_NS    = 0;
   localparam int RECOVERY_MS     = 5;

   function automatic int cyc_min(input int ns);
      cyc_min = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (cyc_min < 1) cyc_min = 1;
   endfunction : cyc_min

   localparam int ADDR_VALID_CYC = cyc_min(ADDR_VALID_NS);
   localparam int DATA_SETUP_CYC = cyc_min(DATA_SETUP_NS);
   localparam int WE_HIZ_CYC     = cyc_min(WE_HIZ_NS);
   localparam int OUT_ACTIVE_CYC = cyc_min(OUT_ACTIVE_NS);
   localparam int READ_CYC       = cyc_min(READ_ACCESS_NS);
   localparam int DESEL_RET_CYC  = cyc_min(DESEL_RET_NS);
   localparam int RECOVERY_CYC   = (RECOVERY_MS * 1000000) / CLK_PERIOD_NS;
   localparam int CNT_W          = 24;

   localparam logic [7:0] WRITE_CYC = 8'(WE_HIZ_CYC + DATA_SETUP_CYC);

   // ----------------------------------------------------------------
   // States and carriers
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,
      ST_WSETUP  = 4'h1,
      ST_WPULSE  = 4'h2,
      ST_WEND    = 4'h3,
      ST_RSETUP  = 4'h4,
      ST_RWAIT   = 4'h5,
      ST_RDONE   = 4'h6,
      ST_RETAIN  = 4'h7,
      ST_RECOVER = 4'h8
   } host_state_t;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic              sel_low_active_n;
      logic              sel_high_active;
      logic              write_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe;
      logic              ctl_oe;
   } pin_bus_t;

endpackage : sram_host_pkg

// [rtl/sram_host_timer.sv]
// Down counter used for the recovery interval of the controller; write and read intervals use the phase counter.
// Assumes the loader holds load for one cycle; done is a registered level.
`timescale 1ns/1ns
module sram_host_timer
   import sram_host_pkg::*;
#(
   parameter int WIDTH = CNT_W
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] value,
   output logic                  done
);
   logic [WIDTH-1:0] count;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         done  <= 1'b1;
      end else if (load) begin
         count <= value;
         done  <= (value == '0);
      end else if (count != '0) begin
         count <= count - WIDTH'(1);
         done  <= (count == WIDTH'(1));
      end
   end
endmodule : sram_host_timer

// [rtl/sram_host_ctrl.sv]
// Host-side controller for an asynchronous 32K x 8 static RAM with
// low-supply data retention. Drives the memory pins and the supply request.
// Assumes one 20 MHz clock and a user port that waits on REQ_READY.
// Behaviour
// - Address changes only while the write strobe and both selects are inactive.
// - The host drives data only while the write strobe is low, never while memory reads out.
// - The chip is deselected before the supply is lowered into retention, at least zero time earlier.
// - In retention by the high-active select, the other pins may float.
// - Address is valid at least 70 ns before the write-ending edge.
// - Write data is stable at least 35 ns before the write-ending edge.
`timescale 1ns/1ns
module sram_host_ctrl
   import sram_host_pkg::*;
#(
   parameter int RECOVERY = RECOVERY_CYC
)(
   input  wire logic              CLOCK,
   input  wire logic              RSTN,
   input  wire logic              REQ_VALID,
   input  wire logic              REQ_WRITE,
   input  wire logic [ADDR_W-1:0] REQ_ADDR,
   input  wire logic [DATA_W-1:0] REQ_WDATA,
   input  wire logic              RETAIN_REQ,
   output logic                   REQ_READY,
   output logic                   RD_VALID,
   output logic      [DATA_W-1:0] RD_DATA,
   output logic                   SUPPLY_LOW,
   output logic                   SELECT_LOW_ACTIVE_N,
   output logic                   SELECT_LOW_ACTIVE_OE,
   output logic                   SELECT_HIGH_ACTIVE,
   output logic                   WRITE_N,
   output logic                   WRITE_OE,
   output logic      [ADDR_W-1:0] ADDR,
   output logic                   ADDR_OE,
   input  wire logic [DATA_W-1:0] DQ_IN,
   output logic      [DATA_W-1:0] DQ_OUT,
   output logic                   DQ_OE
);
   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   host_state_t state;
   host_state_t next_state;
   host_req_t   req;
   logic [7:0]  phase;
   logic        tmr_load;
   logic [CNT_W-1:0] tmr_value;
   logic        tmr_done;

   sram_host_timer #(.WIDTH(CNT_W)) u_timer (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .load  (tmr_load),
      .value (tmr_value),
      .done  (tmr_done)
   );

   always_comb begin
      next_state = state;
      tmr_load   = 1'b0;
      tmr_value  = '0;
      unique case (state)
         ST_IDLE: begin
            if (RETAIN_REQ) begin
               next_state = ST_RETAIN;
            end else if (REQ_VALID && REQ_READY) begin
               next_state = REQ_WRITE ? ST_WSETUP : ST_RSETUP;
            end
         end
         ST_WSETUP:  next_state = ST_WPULSE;
         ST_WPULSE: begin
            if (phase >= WRITE_CYC && phase >= 8'(ADDR_VALID_CYC)) begin
               next_state = ST_WEND;
            end
         end
         ST_WEND:    next_state = ST_IDLE;
         ST_RSETUP:  next_state = ST_RWAIT;
         ST_RWAIT: begin
            if (phase >= 8'(READ_CYC)) next_state = ST_RDONE;
         end
         ST_RDONE:   next_state = ST_IDLE;
         ST_RETAIN: begin
            if (!RETAIN_REQ) begin
               next_state = ST_RECOVER;
               tmr_load   = 1'b1;
               tmr_value  = CNT_W'(RECOVERY);
            end
         end
         ST_RECOVER: begin
            if (tmr_done && !tmr_load) next_state = ST_IDLE;
         end
         default:    next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) state <= ST_IDLE;
      else        state <= next_state;
   end

   // Phase counter restarts on each state change
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n)                   phase <= 8'h00;
      else if (next_state != state) phase <= 8'h00;
      else if (phase != 8'hff)      phase <= phase + 8'h01;
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         req <= '0;
      end else if (state == ST_IDLE && REQ_VALID && REQ_READY && !RETAIN_REQ) begin
         req <= '{write: REQ_WRITE, addr: REQ_ADDR, wdata: REQ_WDATA};
      end
   end

   // ----------------------------------------------------------------
   // Pin drive, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         SELECT_LOW_ACTIVE_N  <= 1'b1;
         SELECT_HIGH_ACTIVE   <= 1'b0;
         WRITE_N              <= 1'b1;
         ADDR                 <= '0;
         DQ_OUT               <= '0;
         DQ_OE                <= 1'b0;
         SELECT_LOW_ACTIVE_OE <= 1'b1;
         WRITE_OE             <= 1'b1;
         ADDR_OE              <= 1'b1;
         SUPPLY_LOW           <= 1'b0;
      end else begin
         // Address moves only with everything inactive
         if (next_state == ST_WSETUP || next_state == ST_RSETUP) begin
            ADDR <= (state == ST_IDLE) ? REQ_ADDR : req.addr;
         end
         // Strobe falls with the selects so the memory never turns on
         WRITE_N <= !(next_state == ST_WPULSE);
         SELECT_LOW_ACTIVE_N <= !(next_state inside {ST_WPULSE, ST_RWAIT, ST_RDONE});
         SELECT_HIGH_ACTIVE  <= (next_state inside {ST_WPULSE, ST_RWAIT, ST_RDONE});
         // Data driven only inside the strobe; released with its rise
         DQ_OE  <= (next_state == ST_WPULSE);
         DQ_OUT <= req.wdata;
         // Floating pins are allowed only while held in retention
         SELECT_LOW_ACTIVE_OE <= (next_state != ST_RETAIN);
         WRITE_OE             <= (next_state != ST_RETAIN);
         ADDR_OE              <= (next_state != ST_RETAIN);
         // Supply drops one cycle after retention is entered, at least two after deselect, which exceeds zero margin
         SUPPLY_LOW <= (state == ST_RETAIN) && (next_state == ST_RETAIN);
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         REQ_READY <= 1'b0;
         RD_VALID  <= 1'b0;
         RD_DATA   <= '0;
      end else begin
         // A request raised before ready must wait, never lock ready low
         REQ_READY <= (next_state == ST_IDLE);
         RD_VALID  <= (state == ST_RDONE);
         if (state == ST_RDONE) RD_DATA <= DQ_IN;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_addr_stable;
      @(posedge CLOCK) disable iff (!rst_n)
      $changed(ADDR) |-> (WRITE_N && SELECT_LOW_ACTIVE_N && !SELECT_HIGH_ACTIVE);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("Address moved while active");

   property p_no_contend;
      @(posedge CLOCK) disable iff (!rst_n)
      DQ_OE |-> !WRITE_N;
   endproperty
   a_no_contend: assert property (p_no_contend) else $error("Data driven outside strobe");

   property p_write_pulse;
      @(posedge CLOCK) disable iff (!rst_n)
      $fell(WRITE_N) |-> (!SELECT_LOW_ACTIVE_N && SELECT_HIGH_ACTIVE && DQ_OE)[*2];
   endproperty
   a_write_pulse: assert property (p_write_pulse) else $error("Write overlap too short");

   property p_select_with_strobe;
      @(posedge CLOCK) disable iff (!rst_n)
      ($fell(SELECT_LOW_ACTIVE_N) && state == ST_WPULSE) |-> $fell(WRITE_N);
   endproperty
   a_select_with_strobe: assert property (p_select_with_strobe) else $error("Select before strobe");

   property p_retain_desel;
      @(posedge CLOCK) disable iff (!rst_n)
      SUPPLY_LOW |-> (!SELECT_HIGH_ACTIVE && $past(!SELECT_HIGH_ACTIVE));
   endproperty
   a_retain_desel: assert property (p_retain_desel) else $error("Supply low while selected");

   property p_float_only_retained;
      @(posedge CLOCK) disable iff (!rst_n)
      !ADDR_OE |-> !SELECT_HIGH_ACTIVE;
   endproperty
   a_float_only_retained: assert property (p_float_only_retained) else $error("Float while on");

   property p_recover;
      @(posedge CLOCK) disable iff (!rst_n)
      $fell(SUPPLY_LOW) |-> !SELECT_HIGH_ACTIVE [*3];
   endproperty
   a_recover: assert property (p_recover) else $error("Access during recovery");

   property p_addr_valid;
      @(posedge CLOCK) disable iff (!rst_n)
      $rose(WRITE_N) |-> $past(ADDR, ADDR_VALID_CYC) == ADDR;
   endproperty
   a_addr_valid: assert property (p_addr_valid) else $error("Address not held before end");

   property p_release;
      @(posedge CLOCK) disable iff (!rst_n)
      $rose(WRITE_N) |-> !DQ_OE;
   endproperty
   a_release: assert property (p_release) else $error("Data held past write end");

   c_write:   cover property (@(posedge CLOCK) disable iff (!rst_n) $rose(WRITE_N));
   c_read:    cover property (@(posedge CLOCK) disable iff (!rst_n) RD_VALID);
   c_retain:  cover property (@(posedge CLOCK) disable iff (!rst_n) $fell(SUPPLY_LOW));
endmodule : sram_host_ctrl

// [sim/sram_model.sv]
// Behavioural 32K x 8 asynchronous static RAM with low-supply retention.
// Assumes floating pins arrive as z; n_err counts faults of the host side.
`timescale 1ns/1ns
module sram_model
   import sram_host_pkg::*;
#(
   parameter int REC_NS = 400
)(
   input  wire logic              sel_n,
   input  wire logic              sel_h,
   input  wire logic              write_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] host_dq,
   input  wire logic              host_oe,
   input  wire logic              supply_low,
   output logic      [DATA_W-1:0] dq,
   output int                     n_err
);
   // ----------------------------------------------------------------
   // Array and decode
   // ----------------------------------------------------------------
   logic    [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic    [DATA_W-1:0] last = '0;
   realtime              t_addr = 0;
   realtime              t_dq = 0;
   realtime              t_up = -1.0e9;
   // A floating low select reads as unknown, so only the high select deselects
   wire                  sel = sel_h && !sel_n;
   wire                  wr = sel && !write_n;
   wire                  rd = sel && write_n;
   wire #READ_ACCESS_NS  rd_late = rd;
   wire                  mem_oe = rd && rd_late;
   // ----------------------------------------------------------------
   // Bus and checks on the host
   // ----------------------------------------------------------------
   // Undriven bus shows the inverse of its last value, never a kind guess
   assign dq = host_oe ? host_dq : (mem_oe ? mem[addr] : ~last);
   always @* if (host_oe || mem_oe) last = dq;
   initial n_err = 0;
   always @(posedge (host_oe && mem_oe)) n_err++;
   always @(addr) begin
      if (wr) n_err++;
      t_addr = $realtime;
   end
   always @(host_dq) t_dq = $realtime;
   always @(negedge wr) begin
      if ($realtime - t_addr < ADDR_VALID_NS) n_err++;
      if ($realtime - t_dq < DATA_SETUP_NS) n_err++;
      mem[addr] = host_dq;
   end
   always @(posedge supply_low) if (sel_h !== 1'b0) n_err++;
   always @(posedge wr) if (supply_low) n_err++;
   always @(negedge supply_low) t_up = $realtime;
   always @(posedge sel) if ($realtime - t_up < REC_NS) n_err++;
endmodule : sram_model

// [sim/test_sram_host_ctrl.sv]
// Self-checking bench for the static RAM host controller.
// Assumes the memory model beside it; recovery shortened to 8 cycles.
`timescale 1ns/1ns
module test_sram_host_ctrl;
   import sram_host_pkg::*;
   localparam int REC = 8;
   logic              CLOCK, RSTN, REQ_VALID, REQ_WRITE, RETAIN_REQ;
   logic [ADDR_W-1:0] REQ_ADDR, ADDR;
   logic [DATA_W-1:0] REQ_WDATA, RD_DATA, DQ_IN, DQ_OUT;
   logic              REQ_READY, RD_VALID, SUPPLY_LOW, SELECT_LOW_ACTIVE_N;
   logic              SELECT_LOW_ACTIVE_OE, SELECT_HIGH_ACTIVE, WRITE_N, WRITE_OE;
   logic              ADDR_OE, DQ_OE;
   int                n_mismatch = 0;
   int                n_checks = 0;
   int                n_err;
   int                c;
   wire               sel_pin = SELECT_LOW_ACTIVE_OE ? SELECT_LOW_ACTIVE_N : 1'bz;
   wire               wr_pin = WRITE_OE ? WRITE_N : 1'bz;
   wire  [ADDR_W-1:0] addr_pin = ADDR_OE ? ADDR : 'z;

   sram_host_ctrl #(.RECOVERY(REC)) sram_host_ctrl_inst (
      .CLOCK(CLOCK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
      .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RETAIN_REQ(RETAIN_REQ),
      .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
      .SUPPLY_LOW(SUPPLY_LOW), .SELECT_LOW_ACTIVE_N(SELECT_LOW_ACTIVE_N),
      .SELECT_LOW_ACTIVE_OE(SELECT_LOW_ACTIVE_OE), .SELECT_HIGH_ACTIVE(SELECT_HIGH_ACTIVE),
      .WRITE_N(WRITE_N), .WRITE_OE(WRITE_OE), .ADDR(ADDR), .ADDR_OE(ADDR_OE),
      .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));
   sram_model #(.REC_NS(REC * CLK_PERIOD_NS)) sram_model_inst (
      .sel_n(sel_pin), .sel_h(SELECT_HIGH_ACTIVE), .write_n(wr_pin), .addr(addr_pin),
      .host_dq(DQ_OUT), .host_oe(DQ_OE), .supply_low(SUPPLY_LOW), .dq(DQ_IN),
      .n_err(n_err));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   initial begin
      CLOCK = 1'b0;
      forever #(CLK_PERIOD_NS / 2) CLOCK = ~CLOCK;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // Sampled on the falling edge, well clear of the registered updates
   task automatic wait_on(input int which, input int lim, output int cnt);
      logic s;
      cnt = 0;
      while (cnt < lim) begin
         @(negedge CLOCK);
         s = (which == 0) ? REQ_READY : (which == 1) ? RD_VALID : SUPPLY_LOW;
         if (s === 1'b1) return;
         cnt++;
      end
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, which, 1);
      wrap_up();
   endtask : wait_on
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int k;
      wait_on(0, 300, k);
      @(posedge CLOCK);
      REQ_VALID <= 1'b1;
      REQ_WRITE <= wr;
      REQ_ADDR  <= a;
      REQ_WDATA <= d;
      @(posedge CLOCK);
      REQ_VALID <= 1'b0;
   endtask : issue
   task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int lw;
      int i;
      lw = 0;
      i  = 0;
      issue(1'b1, a, d);
      // Ready still reads high in the take step, so look only from the next falling edge
      do begin
         @(negedge CLOCK);
         if (WRITE_N === 1'b0) begin
            lw++;
            check({DQ_OE, DQ_IN}, {1'b1, d});
         end
         i++;
      end while (REQ_READY !== 1'b1 && i < 20);
      if (REQ_READY !== 1'b1) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, REQ_READY, 1'b1);
         wrap_up();
      end
      check(lw >= ADDR_VALID_CYC, 1);
   endtask : do_write
   task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int k;
      issue(1'b0, a, '0);
      wait_on(1, 50, k);
      check({DQ_OE, RD_DATA}, {1'b0, d});
   endtask : do_read

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      check({SELECT_LOW_ACTIVE_N, SELECT_HIGH_ACTIVE, WRITE_N, DQ_OE, SUPPLY_LOW, REQ_READY},
            6'b101000);
      $display("test reset done");
   endtask : t_reset
   // Back-to-back writes at both ends of the array, then a read right after a write
   task automatic t_rw;
      logic [ADDR_W-1:0] a [4] = '{15'h0000, 15'h7fff, 15'h1555, 15'h2aaa};
      logic [DATA_W-1:0] d [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
      for (int i = 0; i < 4; i++) do_write(a[i], d[i]);
      for (int i = 0; i < 4; i++) do_read(a[i], d[i]);
      do_write(15'h0001, 8'h3c);
      do_read(15'h0001, 8'h3c);
      $display("test write read done");
   endtask : t_rw
   // Retention asked together with a request: retention wins, data survives
   task automatic t_retain;
      do_write(15'h1234, 8'hc3);
      wait_on(0, 50, c);
      @(posedge CLOCK);
      RETAIN_REQ <= 1'b1;
      REQ_VALID  <= 1'b1;
      REQ_WRITE  <= 1'b0;
      REQ_ADDR   <= 15'h1234;
      wait_on(2, 20, c);
      check({SELECT_HIGH_ACTIVE, REQ_READY, RD_VALID}, 3'b000);
      check({SELECT_LOW_ACTIVE_OE, WRITE_OE, ADDR_OE}, 3'b000);
      repeat (4) @(negedge CLOCK);
      check({SUPPLY_LOW, REQ_READY}, 2'b10);
      @(posedge CLOCK);
      RETAIN_REQ <= 1'b0;
      wait_on(0, 100, c);
      check({SUPPLY_LOW, 1'b0, c >= REC}, 3'b001);
      check({SELECT_LOW_ACTIVE_OE, WRITE_OE, ADDR_OE}, 3'b111);
      @(posedge CLOCK);
      REQ_VALID <= 1'b0;
      wait_on(1, 50, c);
      check(RD_DATA, 8'hc3);
      $display("test retention done");
   endtask : t_retain
   // Reset in mid-run, then a read asked as reset releases; the request must wait, not hang
   task automatic t_reset_busy;
      @(posedge CLOCK);
      RSTN <= 1'b0;
      @(negedge CLOCK);
      check({SELECT_LOW_ACTIVE_N, SELECT_HIGH_ACTIVE, WRITE_N, DQ_OE, SUPPLY_LOW, REQ_READY},
            6'b101000);
      @(posedge CLOCK);
      RSTN      <= 1'b1;
      REQ_VALID <= 1'b1;
      REQ_WRITE <= 1'b0;
      REQ_ADDR  <= 15'h0000;
      wait_on(0, 20, c);
      @(posedge CLOCK);
      REQ_VALID <= 1'b0;
      wait_on(1, 50, c);
      check(RD_DATA, 8'ha5);
      $display("test reset in run done");
   endtask : t_reset_busy

   initial begin
      RSTN       = 1'b0;
      REQ_VALID  = 1'b0;
      REQ_WRITE  = 1'b0;
      REQ_ADDR   = '0;
      REQ_WDATA  = '0;
      RETAIN_REQ = 1'b0;
      repeat (2) @(posedge CLOCK);
      t_reset();
      RSTN <= 1'b1;
      t_rw();
      t_retain();
      do_read(15'h7fff, 8'h5a);
      t_reset_busy();
      check(n_err, 0);
      wrap_up();
   end
endmodule : test_sram_host_ctrl
